// ---- inc/dmas_pkg.sv ----
// shared constants for the dma address and word count slice
package dmas_pkg;
  localparam int DATA_W = 8;
  localparam int MODE_W = 3;
  localparam int DIR_BIT = 2;
  localparam int MODE_LSB = 0;
  localparam int PAD_W = 5;
  // instruction codes
  localparam logic [2:0] INSTR_WRITE_MODE = 3'h0;
  localparam logic [2:0] INSTR_READ_MODE = 3'h1;
  localparam logic [2:0] INSTR_READ_COUNT = 3'h2;
  localparam logic [2:0] INSTR_READ_ADDR = 3'h3;
  localparam logic [2:0] INSTR_RESTORE = 3'h4;
  localparam logic [2:0] INSTR_LOAD_ADDR = 3'h5;
  localparam logic [2:0] INSTR_LOAD_COUNT = 3'h6;
  localparam logic [2:0] INSTR_ENABLE_COUNT = 3'h7;
  // operating modes held in the two mode bits
  localparam logic [1:0] MODE_COUNT_ZERO = 2'h0;
  localparam logic [1:0] MODE_COUNT_CMP = 2'h1;
  localparam logic [1:0] MODE_ADDR_CMP = 2'h2;
  localparam logic [1:0] MODE_CARRY_OUT = 2'h3;
  // values after reset and fixed patterns
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [4:0] READ_MODE_PAD = 5'h1f;
endpackage : dmas_pkg

// ---- verilog/dmas_counter.sv ----
// loadable up/down counter with active-low carry chain
`timescale 1ns/100ps
module dmas_counter #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // control
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  input wire logic count_en,
  input wire logic up,
  input wire logic carry_in_n,
  // state
  output logic [WIDTH-1:0] count_q,
  output logic carry_out_n
);
  logic [WIDTH-1:0] count_d;
  logic terminal;

  // wraps modulo two to the width in either direction
  always_comb begin
    count_d = count_q;
    if (load) begin
      count_d = load_val;
    end else if (count_en && !carry_in_n) begin
      if (up) begin
        count_d = count_q + {{(WIDTH-1){1'b0}}, 1'b1};
      end else begin
        count_d = count_q - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  // ripple out only when this slice is about to roll over
  assign terminal = up ? (&count_q) : (~|count_q);
  assign carry_out_n = !(count_en && !carry_in_n && terminal);
endmodule : dmas_counter

// ---- verilog/dmas_slice.sv ----
// eight-bit dma address generator slice with word count and transfer-complete
`timescale 1ns/100ps
// What this block does
// - low mode bits pick mode, bit two direction
// - address counter steps on enable and carry
// - slices chain through active-low address carries
// - address counter counts, holds, loads data, restores
// - load address fills save and counter
// - word counter up modes 1,3, down 0
// - load count fills counter and save
// - mode 1 load count clears counter
// - word counter steps on enable and carry
// - transfer-complete is combinational, wired-and output
// - mode 0 done at one or zero
// - mode 1 done comparing against saved count
// - mode 2 done when address equals final
// - mode 3 done stays low, carry signals
// - read instructions mux state onto data lines
// - address lines driven only while enable low
// - control decoded from instruction and mode bits
// - all state changes on rising clock edge
// - eight instruction codes from zero to seven
// - mode 2 enable counts only the address
// - restore copies saves, mode 1 clears count
// - mode read pads ones, write ignores them
module dmas_slice (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // instruction from the controller
  input wire logic [2:0] instruction_select,
  // carry chain
  input wire logic addr_carry_in_n,
  output logic addr_carry_out_n,
  input wire logic count_carry_in_n,
  output logic count_carry_out_n,
  // bidirectional data lines
  input wire logic [7:0] data_lines_in,
  output logic [7:0] data_lines_out,
  output logic data_lines_oe,
  // address output lines
  input wire logic addr_out_enable_n,
  output logic [7:0] addr_lines_out,
  output logic addr_lines_oe,
  // open-collector transfer complete
  input wire logic done_in,
  output logic done_out,
  output logic done_oe
);
  logic [2:0] mode_direction_q;
  logic [2:0] mode_direction_d;
  logic [7:0] start_address_save_q;
  logic [7:0] start_address_save_d;
  logic [7:0] saved_count_q;
  logic [7:0] saved_count_d;
  logic [7:0] address_counter;
  logic [7:0] word_counter;
  logic [1:0] mode_bits;
  logic direction_bit;
  logic write_mode_instr;
  logic read_mode_instr;
  logic read_count_instr;
  logic read_addr_instr;
  logic restore_counters_instr;
  logic load_addr_instr;
  logic load_count_instr;
  logic enable_count_instr;
  logic addr_load;
  logic [7:0] addr_load_val;
  logic addr_count_en;
  logic addr_up;
  logic word_load;
  logic [7:0] word_load_val;
  logic word_count_en;
  logic word_up;
  logic [7:0] word_plus_one;
  logic done;

  assign mode_bits = mode_direction_q[dmas_pkg::MODE_LSB +: 2];
  assign direction_bit = mode_direction_q[dmas_pkg::DIR_BIT];

  // instruction decode
  always_comb begin
    write_mode_instr = (instruction_select == dmas_pkg::INSTR_WRITE_MODE);
    read_mode_instr = (instruction_select == dmas_pkg::INSTR_READ_MODE);
    read_count_instr = (instruction_select == dmas_pkg::INSTR_READ_COUNT);
    read_addr_instr = (instruction_select == dmas_pkg::INSTR_READ_ADDR);
    restore_counters_instr = (instruction_select == dmas_pkg::INSTR_RESTORE);
    load_addr_instr = (instruction_select == dmas_pkg::INSTR_LOAD_ADDR);
    load_count_instr = (instruction_select == dmas_pkg::INSTR_LOAD_COUNT);
    enable_count_instr = (instruction_select == dmas_pkg::INSTR_ENABLE_COUNT);
  end

  // counter control depends on instruction and mode bits together
  always_comb begin
    addr_load = load_addr_instr || restore_counters_instr;
    addr_load_val = load_addr_instr ? data_lines_in : start_address_save_q;
    addr_count_en = enable_count_instr;
    // direction bit clear means increment
    addr_up = !direction_bit;
    word_load = load_count_instr || restore_counters_instr;
    if (mode_bits == dmas_pkg::MODE_COUNT_CMP) begin
      word_load_val = dmas_pkg::BYTE_ZERO;
    end else if (load_count_instr) begin
      word_load_val = data_lines_in;
    end else begin
      word_load_val = saved_count_q;
    end
    word_count_en = enable_count_instr && (mode_bits != dmas_pkg::MODE_ADDR_CMP);
    word_up = (mode_bits != dmas_pkg::MODE_COUNT_ZERO);
  end

  // mode register and the two save registers
  always_comb begin
    mode_direction_d = mode_direction_q;
    start_address_save_d = start_address_save_q;
    saved_count_d = saved_count_q;
    if (write_mode_instr) begin
      mode_direction_d = data_lines_in[dmas_pkg::MODE_W-1:0];
    end
    if (load_addr_instr) begin
      start_address_save_d = data_lines_in;
    end
    if (load_count_instr) begin
      saved_count_d = data_lines_in;
    end
  end

  // no reset exists on the slice pins; nrst only gives a known start
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mode_direction_q <= dmas_pkg::MODE_RST;
      start_address_save_q <= dmas_pkg::BYTE_RST;
      saved_count_q <= dmas_pkg::BYTE_RST;
    end else begin
      mode_direction_q <= mode_direction_d;
      start_address_save_q <= start_address_save_d;
      saved_count_q <= saved_count_d;
    end
  end

  dmas_counter #(
    .WIDTH(dmas_pkg::DATA_W)
  ) u_addr_counter (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .load(addr_load),
    .load_val(addr_load_val),
    .count_en(addr_count_en),
    .up(addr_up),
    .carry_in_n(addr_carry_in_n),
    .count_q(address_counter),
    .carry_out_n(addr_carry_out_n)
  );

  dmas_counter #(
    .WIDTH(dmas_pkg::DATA_W)
  ) u_word_counter (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .load(word_load),
    .load_val(word_load_val),
    .count_en(word_count_en),
    .up(word_up),
    .carry_in_n(count_carry_in_n),
    .count_q(word_counter),
    .carry_out_n(count_carry_out_n)
  );

  // transfer complete, no clock between counters and pin
  assign word_plus_one = word_counter + dmas_pkg::BYTE_ONE;
  always_comb begin
    done = 1'b0;
    case (mode_bits)
      dmas_pkg::MODE_COUNT_ZERO: begin
        done = count_carry_in_n ? (word_counter == dmas_pkg::BYTE_ZERO)
                                : (word_counter == dmas_pkg::BYTE_ONE);
      end
      dmas_pkg::MODE_COUNT_CMP: begin
        done = count_carry_in_n ? (word_counter == saved_count_q)
                                : (word_plus_one == saved_count_q);
      end
      dmas_pkg::MODE_ADDR_CMP: begin
        done = (address_counter == word_counter);
      end
      default: begin
        done = 1'b0;
      end
    endcase
  end
  // pull low when not complete so slices combine as wired-and
  assign done_out = 1'b0;
  assign done_oe = !done;

  // data mux; a read drives for as long as the instruction stays
  always_comb begin
    data_lines_out = dmas_pkg::BYTE_ZERO;
    data_lines_oe = 1'b0;
    if (read_mode_instr) begin
      data_lines_out = {dmas_pkg::READ_MODE_PAD, mode_direction_q};
      data_lines_oe = 1'b1;
    end else if (read_count_instr) begin
      data_lines_out = word_counter;
      data_lines_oe = 1'b1;
    end else if (read_addr_instr) begin
      data_lines_out = address_counter;
      data_lines_oe = 1'b1;
    end
  end

  assign addr_lines_out = address_counter;
  assign addr_lines_oe = !addr_out_enable_n;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_load_addr;
    instruction_select == dmas_pkg::INSTR_LOAD_ADDR;
  endsequence

  sequence s_load_count;
    instruction_select == dmas_pkg::INSTR_LOAD_COUNT;
  endsequence

  sequence s_restore;
    instruction_select == dmas_pkg::INSTR_RESTORE;
  endsequence

  sequence s_hold_two;
    (instruction_select == dmas_pkg::INSTR_READ_MODE) [*2];
  endsequence

  a_load_addr_both: assert property (
    s_load_addr |=> (address_counter == $past(data_lines_in)) &&
                    (start_address_save_q == $past(data_lines_in)))
    else $error("load address did not fill counter and save");

  a_load_count_full: assert property (
    s_load_count and (mode_bits != dmas_pkg::MODE_COUNT_CMP) |=>
      (word_counter == $past(data_lines_in)) && (saved_count_q == $past(data_lines_in)))
    else $error("load count did not fill counter and save");

  a_load_count_clear: assert property (
    s_load_count and (mode_bits == dmas_pkg::MODE_COUNT_CMP) |=>
      (word_counter == dmas_pkg::BYTE_ZERO) && (saved_count_q == $past(data_lines_in)))
    else $error("mode 1 load count did not clear counter");

  a_restore_saved: assert property (
    s_load_addr ##1 s_load_count ##1 s_restore |=>
      (address_counter == $past(data_lines_in, 3)) &&
      (word_counter == ((mode_bits == dmas_pkg::MODE_COUNT_CMP) ?
                        dmas_pkg::BYTE_ZERO : $past(data_lines_in, 2))))
    else $error("restore did not bring back saved values");

  a_addr_step: assert property (
    enable_count_instr && !addr_carry_in_n |=>
      address_counter == ($past(direction_bit) ? $past(address_counter) - dmas_pkg::BYTE_ONE
                                               : $past(address_counter) + dmas_pkg::BYTE_ONE))
    else $error("address counter did not step");

  a_addr_hold: assert property (
    (enable_count_instr && addr_carry_in_n) or s_hold_two |=> $stable(address_counter))
    else $error("address counter moved without carry");

  a_word_dir: assert property (
    enable_count_instr && !count_carry_in_n && (mode_bits == dmas_pkg::MODE_COUNT_ZERO) |=>
      word_counter == $past(word_counter) - dmas_pkg::BYTE_ONE)
    else $error("mode 0 word counter did not decrement");

  a_word_up: assert property (
    enable_count_instr && !count_carry_in_n && mode_bits[0] |=>
      word_counter == $past(word_counter) + dmas_pkg::BYTE_ONE)
    else $error("word counter did not increment");

  a_mode2_hold: assert property (
    enable_count_instr && (mode_bits == dmas_pkg::MODE_ADDR_CMP) |=> $stable(word_counter))
    else $error("mode 2 word counter moved");

  a_done_zero: assert property (
    (mode_bits == dmas_pkg::MODE_COUNT_ZERO) && !count_carry_in_n |->
      (!done_oe) == (word_counter == dmas_pkg::BYTE_ONE))
    else $error("mode 0 done wrong");

  a_done_compare: assert property (
    (mode_bits == dmas_pkg::MODE_COUNT_CMP) && count_carry_in_n |->
      (!done_oe) == (word_counter == saved_count_q))
    else $error("mode 1 done wrong");

  a_done_addr: assert property (
    (mode_bits == dmas_pkg::MODE_ADDR_CMP) |-> (!done_oe) == (address_counter == word_counter))
    else $error("mode 2 done wrong");

  a_done_low: assert property (
    (mode_bits == dmas_pkg::MODE_CARRY_OUT) |-> done_oe && !done_in)
    else $error("mode 3 done not low");

  a_mode_pad: assert property (
    (instruction_select == dmas_pkg::INSTR_WRITE_MODE) ##1 read_mode_instr |->
      data_lines_oe && (data_lines_out == {dmas_pkg::READ_MODE_PAD, $past(data_lines_in[2:0])}))
    else $error("mode readback wrong");

  a_data_float: assert property (
    instruction_select[2] |-> !data_lines_oe)
    else $error("data lines driven outside a read");

  a_addr_drive: assert property (
    addr_lines_oe == !addr_out_enable_n && addr_lines_out == address_counter)
    else $error("address output enable wrong");

  a_carry_wrap: assert property (
    enable_count_instr && !addr_carry_in_n && !direction_bit &&
      (address_counter == 8'hff) |-> !addr_carry_out_n ##1 address_counter == dmas_pkg::BYTE_ZERO)
    else $error("address carry or wrap wrong");
endmodule : dmas_slice

// ---- dv/dmas_ctrl_model.sv ----
// controller-side model: drives the data lines, resolves address bus and wired done
`timescale 1ns/100ps
module dmas_ctrl_model (
  // clock
  input wire logic clk_sys,
  // controller drive of the data lines
  input wire logic drv_en,
  input wire logic [7:0] drv_val,
  // device side
  input wire logic [7:0] dev_out,
  input wire logic dev_oe,
  input wire logic [7:0] addr_out,
  input wire logic addr_oe,
  input wire logic done_out,
  input wire logic done_oe,
  // resolved lines
  output logic [7:0] data_bus,
  output logic [7:0] addr_bus,
  output logic done_wire
);
  logic [7:0] float_q = 8'ha5;
  // floating lines wander so a stale value never passes for a driven one
  always @(posedge clk_sys) begin
    float_q <= ~float_q;
  end
  always_comb begin
    if (dev_oe && drv_en) begin
      data_bus = 8'hxx;
    end else if (dev_oe) begin
      data_bus = dev_out;
    end else if (drv_en) begin
      data_bus = drv_val;
    end else begin
      data_bus = float_q;
    end
  end
  assign addr_bus = addr_oe ? addr_out : float_q;
  // pull-up on the wired-and line
  assign done_wire = done_oe ? done_out : 1'b1;
endmodule : dmas_ctrl_model

// ---- dv/tb_dmas_slice.sv ----
// self-checking bench for the dma address and word count slice
`timescale 1ns/100ps
module tb_dmas_slice;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] instr = 3'h0;
  logic aci_n = 1'b1;
  logic wci_n = 1'b1;
  logic oea_n = 1'b1;
  logic drv_en = 1'b1;
  logic [7:0] drv_val = 8'h00;
  logic aco_n, wco_n, d_oe, a_oe, dn_out, dn_oe, done_w;
  logic [7:0] bus, d_out, a_out, a_bus;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  always #20 clk_sys = ~clk_sys;
  dmas_slice i_dut (
    .clk_sys(clk_sys), .nrst(nrst), .instruction_select(instr),
    .addr_carry_in_n(aci_n), .addr_carry_out_n(aco_n),
    .count_carry_in_n(wci_n), .count_carry_out_n(wco_n),
    .data_lines_in(bus), .data_lines_out(d_out), .data_lines_oe(d_oe),
    .addr_out_enable_n(oea_n), .addr_lines_out(a_out), .addr_lines_oe(a_oe),
    .done_in(done_w), .done_out(dn_out), .done_oe(dn_oe)
  );
  dmas_ctrl_model i_ctrl (
    .clk_sys(clk_sys), .drv_en(drv_en), .drv_val(drv_val), .dev_out(d_out),
    .dev_oe(d_oe), .addr_out(a_out), .addr_oe(a_oe), .done_out(dn_out),
    .done_oe(dn_oe), .data_bus(bus), .addr_bus(a_bus), .done_wire(done_w)
  );
  task close_out;
    if (err_total == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk8
  task chk1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask : chk1
  // one instruction executed at the next rising edge, checked just after it
  task op(input logic [2:0] i, input logic [7:0] d);
    @(negedge clk_sys);
    instr = i;
    drv_en = 1'b1;
    drv_val = d;
    @(posedge clk_sys);
    #2;
  endtask : op
  task rd(input logic [2:0] i, input logic [7:0] exp);
    @(negedge clk_sys);
    instr = i;
    drv_en = 1'b0;
    #2;
    chk8(bus, exp);
  endtask : rd
  task carry(input logic ac, input logic wc, input logic oe);
    @(negedge clk_sys);
    aci_n = ac;
    wci_n = wc;
    oea_n = oe;
  endtask : carry
  task st(input logic [7:0] a, input logic ao, input logic wo, input logic dn);
    chk8(a_bus, a);
    chk1(aco_n, ao);
    chk1(wco_n, wo);
    chk1(done_w, dn);
  endtask : st
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    nrst = 1'b1;
    // carries idle, so enable and restore leave the zeroed state alone
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_sys);
      instr = i[2:0];
      drv_en = !(i inside {1, 2, 3});
      #2;
      chk1(d_oe, i inside {1, 2, 3});
    end
    rd(3'h1, 8'hf8);
    chk1(a_oe, 1'b0);
    op(3'h0, 8'h1d);
    rd(3'h1, 8'hfd);
    rd(3'h1, 8'hfd);
    op(3'h0, 8'h00);
    op(3'h5, 8'hfe);
    op(3'h6, 8'h02);
    carry(1'b0, 1'b0, 1'b0);
    rd(3'h3, 8'hfe);
    rd(3'h2, 8'h02);
    op(3'h7, 8'h00);
    st(8'hff, 1'b0, 1'b1, 1'b1);
    op(3'h7, 8'h00);
    st(8'h00, 1'b1, 1'b0, 1'b0);
    carry(1'b1, 1'b1, 1'b0);
    op(3'h7, 8'h00);
    st(8'h00, 1'b1, 1'b1, 1'b1);
    op(3'h4, 8'h00);
    st(8'hfe, 1'b1, 1'b1, 1'b0);
    op(3'h0, 8'h05);
    op(3'h6, 8'h03);
    rd(3'h2, 8'h00);
    carry(1'b0, 1'b0, 1'b0);
    op(3'h7, 8'h00);
    st(8'hfd, 1'b1, 1'b1, 1'b0);
    op(3'h7, 8'h00);
    st(8'hfc, 1'b1, 1'b1, 1'b1);
    carry(1'b1, 1'b1, 1'b0);
    op(3'h7, 8'h00);
    st(8'hfc, 1'b1, 1'b1, 1'b0);
    op(3'h4, 8'h00);
    carry(1'b0, 1'b0, 1'b0);
    rd(3'h2, 8'h00);
    rd(3'h3, 8'hfe);
    op(3'h0, 8'h02);
    op(3'h5, 8'h10);
    op(3'h6, 8'h12);
    op(3'h4, 8'h00);
    st(8'h10, 1'b1, 1'b1, 1'b0);
    op(3'h7, 8'h00);
    st(8'h11, 1'b1, 1'b1, 1'b0);
    op(3'h7, 8'h00);
    st(8'h12, 1'b1, 1'b1, 1'b1);
    rd(3'h2, 8'h12);
    op(3'h0, 8'h03);
    op(3'h6, 8'hfe);
    op(3'h7, 8'h00);
    st(8'h13, 1'b1, 1'b0, 1'b0);
    op(3'h7, 8'h00);
    st(8'h14, 1'b1, 1'b1, 1'b0);
    rd(3'h2, 8'h00);
    close_out();
  end
endmodule : tb_dmas_slice
